// ---- core/integer_divider_cfg.svh ----
`ifndef INTEGER_DIVIDER_CFG_SVH
`define INTEGER_DIVIDER_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_DIVIDEND 8'h00
`define OFF_DIVISOR 8'h04
`define OFF_QUOTIENT 8'h08
`define OFF_REMAINDER 8'h0C
`define OFF_STATUS 8'h10
`define OFF_CONTROL 8'h14
`define OFF_IRQ_STATUS 8'h18
`define OFF_IRQ_CLEAR 8'h1C
`define OFF_IRQ_ENABLE 8'h20

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_DIVIDEND 32'h0000_0000
`define RST_DIVISOR 32'h0000_0001
`define RST_RESULT 32'h0000_0000
`define RST_CONTROL 2'h1
`define RST_IRQ_ENABLE 2'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_SIGN_MODE 0
`define BIT_ZDIV_IRQ_EN 1
`define BIT_ZERO_FLAG 0
`define IRQ_BIT_ZDIV 0
`define IRQ_BIT_DONE 1

// ----------------------------------------
// timing
// ----------------------------------------
`define DIV_CYCLES 8
`define DIV_LAST_STEP 3'h7

`endif

// ---- core/integer_divider_pkg.sv ----
package integer_divider_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } div_state_t;

    typedef struct packed {
        logic [31:0] quot;
        logic [31:0] rem;
    } div_result_t;

    typedef struct packed {
        logic zero_div_irq_enable;
        logic sign_mode_select;
    } div_ctrl_t;

endpackage

// ---- core/integer_divider.sv ----
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "integer_divider_cfg.svh"

// Contract
// - dividend, divisor rw; quotient, remainder read-only
// - control bit 0: 1 unsigned, 0 signed
// - divisor write starts a new division
// - division completes within eight bus cycles
// - results load into quotient and remainder
// - result or status reads stall until done
// - status bit 0 shows zero divisor
// - zero flag clears as each division starts
// - control bit 1 gates zero-divide interrupt
// - divisor, control, irq enable reset 1; others zero
// - unused status and control bits read zero
module integer_divider
    import integer_divider_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESETN,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic O_IRQ
);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [31:0] magnitude(input logic [31:0] x, input logic neg);
        magnitude = neg ? 32'(-x) : x;
    endfunction

    // four restoring steps per cycle, so 32 bits take eight cycles
    function automatic div_result_t step4(input div_result_t cur, input logic [31:0] d);
        logic [32:0] t;
        div_result_t r;
        r = cur;
        t = '0;
        for (int k = 0; k < 4; k++) begin
            t = {r.rem, r.quot[31]};
            r.quot = {r.quot[30:0], 1'b0};
            if (t >= {1'b0, d}) begin
                t = t - {1'b0, d};
                r.quot[0] = 1'b1;
            end
            r.rem = t[31:0];
        end
        step4 = r;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] dvd_q;
    logic [31:0] dvs_q;
    logic [31:0] quot_q;
    logic [31:0] rem_q;
    div_ctrl_t ctrl_q;
    logic flag_q;
    logic [1:0] ist_q;
    logic [1:0] ien_q;
    div_state_t st_q;
    logic [2:0] cnt_q;
    div_result_t part_q;
    logic [31:0] dmag_q;
    logic negq_q;
    logic negr_q;
    logic zero_q;
    logic [31:0] opa_q;
    logic [31:0] opb_q;
    logic op_sgn_q;
    logic [31:0] prdata_q;
    logic fresh_q;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire acc = I_PSEL & I_PENABLE;
    wire wr = acc & I_PWRITE;
    wire sel_dvd = I_PADDR == `OFF_DIVIDEND;
    wire sel_dvs = I_PADDR == `OFF_DIVISOR;
    wire sel_quo = I_PADDR == `OFF_QUOTIENT;
    wire sel_rem = I_PADDR == `OFF_REMAINDER;
    wire sel_sr = I_PADDR == `OFF_STATUS;
    wire sel_cr = I_PADDR == `OFF_CONTROL;
    wire sel_ist = I_PADDR == `OFF_IRQ_STATUS;
    wire sel_icl = I_PADDR == `OFF_IRQ_CLEAR;
    wire sel_ien = I_PADDR == `OFF_IRQ_ENABLE;
    wire mapped = sel_dvd | sel_dvs | sel_quo | sel_rem | sel_sr | sel_cr | sel_ist | sel_icl | sel_ien;
    wire stall_addr = (sel_quo | sel_rem | sel_sr) & ~I_PWRITE;
    wire busy = st_q == ST_RUN;

    logic [31:0] rd_mux;
    always_comb begin
        if (sel_dvd) begin
            rd_mux = dvd_q;
        end else if (sel_dvs) begin
            rd_mux = dvs_q;
        end else if (sel_quo) begin
            rd_mux = quot_q;
        end else if (sel_rem) begin
            rd_mux = rem_q;
        end else if (sel_sr) begin
            rd_mux = {31'h0, flag_q};
        end else if (sel_cr) begin
            rd_mux = {30'h0, ctrl_q};
        end else if (sel_ist) begin
            rd_mux = {30'h0, ist_q};
        end else if (sel_ien) begin
            rd_mux = {30'h0, ien_q};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // result reads wait for a capture taken while idle
    assign O_PREADY = ~stall_addr | fresh_q;
    assign O_PSLVERR = acc & ~mapped;
    assign O_PRDATA = prdata_q;

    // ----------------------------------------
    // divider control
    // ----------------------------------------
    wire start = wr & sel_dvs;
    wire finish = busy & (cnt_q == `DIV_LAST_STEP) & ~start;
    wire sgn = ~ctrl_q.sign_mode_select;
    wire a_neg = sgn & dvd_q[31];
    wire b_neg = sgn & I_PWDATA[31];
    wire div_result_t nxt = step4(part_q, dmag_q);
    // zero divisor keeps the all-ones quotient whatever the signs
    wire [31:0] q_fix = (negq_q & ~zero_q) ? 32'(-nxt.quot) : nxt.quot;
    wire [31:0] r_fix = negr_q ? 32'(-nxt.rem) : nxt.rem;

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
        end else if (start) begin
            st_q <= ST_RUN;
            cnt_q <= 3'h0;
        end else if (finish) begin
            st_q <= ST_IDLE;
        end else if (busy) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // operands latched at start, later dividend writes do not disturb a run
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            part_q <= '0;
            dmag_q <= 32'h0000_0001;
            negq_q <= 1'b0;
            negr_q <= 1'b0;
            zero_q <= 1'b0;
            opa_q <= 32'h0000_0000;
            opb_q <= 32'h0000_0001;
            op_sgn_q <= 1'b0;
        end else if (start) begin
            part_q <= '{quot: magnitude(dvd_q, a_neg), rem: 32'h0000_0000};
            dmag_q <= magnitude(I_PWDATA, b_neg);
            negq_q <= a_neg ^ b_neg;
            negr_q <= a_neg;
            zero_q <= I_PWDATA == 32'h0000_0000;
            opa_q <= dvd_q;
            opb_q <= I_PWDATA;
            op_sgn_q <= sgn;
        end else if (busy) begin
            part_q <= nxt;
        end
    end

    // zero divisor runs the same steps: all-ones magnitude, dividend as remainder
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            quot_q <= `RST_RESULT;
            rem_q <= `RST_RESULT;
        end else if (finish) begin
            quot_q <= q_fix;
            rem_q <= r_fix;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            flag_q <= 1'b0;
        end else if (start) begin
            flag_q <= 1'b0;
        end else if (finish) begin
            flag_q <= zero_q;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            dvd_q <= `RST_DIVIDEND;
            dvs_q <= `RST_DIVISOR;
            ctrl_q <= `RST_CONTROL;
            ien_q <= `RST_IRQ_ENABLE;
        end else if (wr) begin
            if (sel_dvd) begin
                dvd_q <= I_PWDATA;
            end
            if (sel_dvs) begin
                dvs_q <= I_PWDATA;
            end
            if (sel_cr) begin
                ctrl_q <= I_PWDATA[1:0];
            end
            if (sel_ien) begin
                ien_q <= I_PWDATA[1:0];
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            prdata_q <= 32'h0000_0000;
            fresh_q <= 1'b0;
        end else if (I_PSEL) begin
            prdata_q <= rd_mux;
            fresh_q <= ~busy & ~start;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    wire [1:0] ev = {finish, finish & zero_q};
    wire [1:0] clr = (wr & sel_icl) ? I_PWDATA[1:0] : 2'h0;
    wire [1:0] eff_en = {ien_q[`IRQ_BIT_DONE], ien_q[`IRQ_BIT_ZDIV] & ctrl_q.zero_div_irq_enable};

    // a new event beats a clear in the same cycle
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ist_q <= 2'h0;
        end else begin
            ist_q <= (ist_q & ~clr) | ev;
        end
    end

    assign O_IRQ = |(ist_q & eff_en);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    ro_regs_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        wr & (sel_quo | sel_rem) & ~finish |=> $stable(quot_q) && $stable(rem_q))
        else $error("read-only result changed by a write");

    mode_latch_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        start |=> op_sgn_q == !$past(ctrl_q.sign_mode_select))
        else $error("sign mode not taken from control bit 0");

    start_run_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        start |=> busy && cnt_q == 3'h0 && opb_q == $past(I_PWDATA))
        else $error("divisor write did not start a division");

    run_length_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        start ##1 (!start)[*8] |=> !busy && $past(busy))
        else $error("division did not end after eight cycles");

    result_ok_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        finish && !zero_q |=> 32'(quot_q * opb_q + rem_q) == opa_q)
        else $error("quotient times divisor plus remainder is not the dividend");

    read_stall_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        acc && stall_addr && busy |-> !O_PREADY)
        else $error("result read not stalled during a division");

    zero_flag_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        finish |=> flag_q == (opb_q == 32'h0000_0000))
        else $error("zero flag disagrees with divisor");

    flag_clear_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        start |=> (!flag_q && busy) [*8])
        else $error("zero flag not cleared at division start");

    zdiv_irq_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        !ien_q[`IRQ_BIT_DONE] && !ctrl_q.zero_div_irq_enable |-> !O_IRQ)
        else $error("interrupt raised while enable bit clear");

    upper_zero_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        acc && O_PREADY && (sel_sr || sel_cr) && !I_PWRITE |-> O_PRDATA[31:2] == 30'h0)
        else $error("unused status or control bits not zero");

    rem_sign_a: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_RESETN)
        finish && op_sgn_q && !zero_q |=> rem_q == 32'h0000_0000 || rem_q[31] == opa_q[31])
        else $error("signed remainder sign differs from dividend");

endmodule

// ---- sim/apb_host_model.sv ----
`timescale 1ns/100ps
module apb_host_model (
    input wire logic i_clk,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [7:0] o_paddr,
    output logic [31:0] o_pwdata,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr
);
    initial begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0000_0000;
    end

    // ----------------------------------------
    // one transfer, n counts wait states
    // ----------------------------------------
    // no limit here: only the bench watchdog ends a hung access
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output int n);
        n = 0;
        @(posedge i_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'b1;
        @(posedge i_clk);
        while (i_pready !== 1'b1) begin
            n++;
            @(posedge i_clk);
        end
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // released lines show inverted data, never the last value
        o_pwrite <= ~w;
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
endmodule

// ---- sim/hw_integer_divider_tb.sv ----
`timescale 1ns/100ps
`include "integer_divider_cfg.svh"
module hw_integer_divider_tb
    import integer_divider_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int n_fail = 0;
    int check_count = 0;
    int waits;

    always #12.5 clk = ~clk;

    integer_divider integer_divider_inst (
        .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq)
    );
    apb_host_model apb_host_model_inst (
        .i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr)
    );

    // ----------------------------------------
    // compare and bus helpers
    // ----------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb_host_model_inst.xfer(1'b1, a, d, rdat, err, waits);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rdat, err, waits);
        chk32(rdat, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(`OFF_DIVIDEND, 32'h0000_0000);
        rd(`OFF_DIVISOR, 32'h0000_0001);
        rd(`OFF_QUOTIENT, 32'h0000_0000);
        rd(`OFF_REMAINDER, 32'h0000_0000);
        rd(`OFF_STATUS, 32'h0000_0000);
        rd(`OFF_CONTROL, 32'h0000_0001);
    endtask
    task automatic t_regs;
        wr(`OFF_DIVIDEND, 32'hA5A5_5A5A);
        rd(`OFF_DIVIDEND, 32'hA5A5_5A5A);
        wr(`OFF_QUOTIENT, 32'h1234_5678);
        rd(`OFF_QUOTIENT, 32'h0000_0000);
        wr(`OFF_CONTROL, 32'hFFFF_FFFF);
        rd(`OFF_CONTROL, 32'h0000_0003);
        wr(`OFF_STATUS, 32'hFFFF_FFFF);
        rd(`OFF_STATUS, 32'h0000_0000);
        rd(8'h24, 32'h0000_0000);
        chk1(err, 1'b1);
    endtask
    task automatic t_div(input logic sgn, input logic [31:0] a, input logic [31:0] b);
        logic [31:0] q;
        logic [31:0] r;
        // zero divisor: all-ones quotient, dividend kept as remainder
        q = 32'hFFFF_FFFF;
        r = a;
        if (b != 32'h0 && sgn) begin
            q = $signed(a) / $signed(b);
            r = $signed(a) % $signed(b);
        end else if (b != 32'h0) begin
            q = a / b;
            r = a % b;
        end
        wr(`OFF_CONTROL, {31'h0, ~sgn});
        wr(`OFF_DIVIDEND, a);
        wr(`OFF_DIVISOR, b);
        rd(`OFF_QUOTIENT, q);
        chk1(waits > 0 && waits < 9, 1'b1);
        rd(`OFF_REMAINDER, r);
        rd(`OFF_STATUS, {31'h0, b == 32'h0});
    endtask
    task automatic t_irq(input logic [31:0] ctl, input logic exp);
        wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
        wr(`OFF_CONTROL, ctl);
        wr(`OFF_DIVISOR, 32'h0000_0000);
        rd(`OFF_STATUS, 32'h0000_0001);
        rd(`OFF_IRQ_STATUS, 32'h0000_0003);
        @(negedge clk);
        chk1(irq, exp);
        wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
        rd(`OFF_IRQ_STATUS, 32'h0000_0000);
        @(negedge clk);
        chk1(irq, 1'b0);
    endtask
    // done event alone, zero-divide source masked off
    task automatic t_done_irq;
        wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0002);
        rd(`OFF_IRQ_ENABLE, 32'h0000_0002);
        wr(`OFF_DIVIDEND, 32'h0000_0009);
        wr(`OFF_DIVISOR, 32'h0000_0003);
        rd(`OFF_QUOTIENT, 32'h0000_0003);
        rd(`OFF_IRQ_STATUS, 32'h0000_0002);
        @(negedge clk);
        chk1(irq, 1'b1);
        wr(`OFF_IRQ_CLEAR, 32'h0000_0002);
        @(negedge clk);
        chk1(irq, 1'b0);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0001);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_regs;
        t_div(1'b0, 32'd100, 32'd7);
        t_div(1'b0, -32'sd100, 32'd7);
        t_div(1'b1, -32'sd100, 32'd7);
        t_div(1'b1, 32'd100, -32'sd7);
        t_div(1'b1, -32'sd9, 32'h0);
        t_div(1'b0, 32'd5, 32'd3);
        t_irq(32'h0000_0003, 1'b1);
        t_irq(32'h0000_0001, 1'b0);
        t_done_irq;
        end_sim;
    end
    // tests need well under a thousand cycles; allow twenty thousand
    initial begin
        #500000;
        n_fail++;
        end_sim;
    end
endmodule
